// [logic/lieh_cfg.svh]
// Summary of operation
// RL1: latch bus reinit flag, bit 17, when the physical layer enters bus reset.
// RL2: set node ident done, bit 16, when the identification packet stream completes.
// RL3: clear node ident done in the same cycle the bus reinit flag sets; only a hardware set clears it, a host set-view write of bit 17 does not.
// RL4: bits 15 to 10 are reserved, read zero, writes ignored.
// RL5: set bit 9 when a lock response to a register lock gets no ack_complete.
// RL6: set bit 8 on host bus fault while storing an acknowledged write request.
// RL7: bit 7 is unlatched OR of receive channel event bits each ANDed with its enable bit.
// RL8: bit 6 is unlatched OR of transmit channel event bits each ANDed with its enable bit.
// RL9: set bit 5 after a packet lands in the response receive buffer.
// RL10: set bit 4 after a packet lands in the request receive buffer.
// RL11: set bit 3 on response receive descriptor completion when it asks to interrupt.
// RL12: set bit 2 on request receive descriptor completion when it asks to interrupt.
// RL13: set bit 1 on response transmit command completion when it asks to interrupt.
// RL14: set bit 0 on request transmit command completion when it asks to interrupt.
// RL15: set view and clear view; clear view read returns events ANDed with enables.
// RL16: write one sets at set view, clears at clear view; hardware set wins.
// RL17: host writes never alter the two summary bits.
`ifndef LIEH_CFG_SVH
`define LIEH_CFG_SVH
`define LIEH_OFS_SET 8'h80
`define LIEH_OFS_CLR 8'h84
`define LIEH_OFS_STAT 8'h90
`define LIEH_OFS_MASK 8'h94
`define LIEH_BIT_BUS_REINIT 17
`define LIEH_BIT_NODE_IDENT 16
`define LIEH_BIT_RX_SUM 7
`define LIEH_BIT_TX_SUM 6
`define LIEH_LATCH_MASK 18'h3033F
`define LIEH_EVT_RESET 18'h00000
`define LIEH_MASK_RESET 18'h00000
`endif

// [logic/lieh_pkg.sv]
package lieh_pkg;
  typedef logic [17:0] lieh_evt_t;
  typedef enum logic [2:0] {
    LIEH_IDLE = 3'h1,
    LIEH_RESP = 3'h2,
    LIEH_WAIT = 3'h4
  } lieh_bus_state_t;
endpackage

// [logic/lieh_event_low.sv]
`timescale 1ns/100ps
`include "lieh_cfg.svh"
module lieh_event_low
#(
  parameter int NCHAN = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // hardware event pulses
  input wire logic phy_bus_reset,
  input wire logic ident_stream_done,
  input wire logic lock_resp_no_ack,
  input wire logic posted_write_fault,
  input wire logic response_packet_stored,
  input wire logic request_packet_stored,
  input wire logic resp_rx_dma_done,
  input wire logic req_rx_dma_done,
  input wire logic response_send_done,
  input wire logic request_send_done,
  // per-descriptor interrupt requests qualifying the dma completions
  input wire logic [3:0] dma_irq_req,
  // per-channel timed registers
  input wire logic [NCHAN-1:0] rx_chan_event,
  input wire logic [NCHAN-1:0] rx_chan_enable,
  input wire logic [NCHAN-1:0] tx_chan_event,
  input wire logic [NCHAN-1:0] tx_chan_enable,
  // event outputs
  output lieh_pkg::lieh_evt_t event_flags,
  output logic irq
);
  import lieh_pkg::*;

  lieh_evt_t evt_q, evt_d;
  lieh_evt_t mask_q, mask_d;
  lieh_evt_t hw_set;
  lieh_evt_t wr_set, wr_clr, wval, view;
  lieh_bus_state_t st_q, st_d;
  logic [31:0] rdata_q, rdata_d;
  logic rx_sum, tx_sum, wr_hit_q, wr_hit_d, irq_d;
  logic [17:0] full_evt;

  // summaries follow the channel registers, never latched
  assign rx_sum = |(rx_chan_event & rx_chan_enable); // see RL7
  assign tx_sum = |(tx_chan_event & tx_chan_enable); // see RL8

  always_comb
  begin
    hw_set = '0;
    hw_set[17] = phy_bus_reset; // see RL1
    hw_set[16] = ident_stream_done; // see RL2
    hw_set[9] = lock_resp_no_ack; // see RL5
    hw_set[8] = posted_write_fault; // see RL6
    hw_set[5] = response_packet_stored; // see RL9
    hw_set[4] = request_packet_stored; // see RL10
    hw_set[3] = resp_rx_dma_done & dma_irq_req[3]; // see RL11
    hw_set[2] = req_rx_dma_done & dma_irq_req[2]; // see RL12
    hw_set[1] = response_send_done & dma_irq_req[1]; // see RL13
    hw_set[0] = request_send_done & dma_irq_req[0]; // see RL14
  end

  // byte enables gate the written ones; reserved and summary bits masked off
  always_comb
  begin
    wval = {avs_byteenable[2] ? avs_writedata[17:16] : 2'h0,
            avs_byteenable[1] ? avs_writedata[15:8] : 8'h00,
            avs_byteenable[0] ? avs_writedata[7:0] : 8'h00};
    wval = wval & lieh_evt_t'(`LIEH_LATCH_MASK); // see RL4, RL17
  end

  // one-shot write: the write takes effect only in the cycle waitrequest drops
  assign wr_hit_d = (st_q == LIEH_IDLE) & avs_write;
  assign wr_set = (wr_hit_q && avs_address == `LIEH_OFS_SET) ? wval : '0; // see RL16
  assign wr_clr = (wr_hit_q && avs_address == `LIEH_OFS_CLR) ? wval : '0; // see RL16

  always_comb
  begin
    evt_d = (evt_q | wr_set) & ~wr_clr;
    evt_d = evt_d | hw_set; // see RL16
    if (hw_set[`LIEH_BIT_BUS_REINIT] && !evt_q[`LIEH_BIT_BUS_REINIT])
    begin
      evt_d[`LIEH_BIT_NODE_IDENT] = 1'b0; // see RL3
    end
    evt_d = evt_d & lieh_evt_t'(`LIEH_LATCH_MASK); // see RL4
    mask_d = mask_q;
    if (wr_hit_q && avs_address == `LIEH_OFS_MASK)
    begin
      mask_d = wval | (avs_byteenable[0] ? {10'h000, avs_writedata[7:6], 6'h00} : 18'h00000);
    end
  end

  always_comb
  begin
    full_evt = evt_q;
    full_evt[`LIEH_BIT_RX_SUM] = rx_sum;
    full_evt[`LIEH_BIT_TX_SUM] = tx_sum;
    view = full_evt;
  end

  // bus: idle -> resp (waitrequest low) -> wait for one cycle -> idle
  always_comb
  begin
    st_d = st_q;
    rdata_d = rdata_q;
    case (st_q)
      LIEH_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          st_d = LIEH_RESP;
          rdata_d = 32'h00000000;
          if (avs_read)
          begin
            case (avs_address)
              `LIEH_OFS_SET: rdata_d = {14'h0000, view};
              `LIEH_OFS_CLR: rdata_d = {14'h0000, view & mask_q}; // see RL15
              `LIEH_OFS_MASK: rdata_d = {14'h0000, mask_q};
              default: rdata_d = 32'h00000000;
            endcase
          end
        end
      end
      LIEH_RESP: st_d = LIEH_WAIT;
      LIEH_WAIT: st_d = LIEH_IDLE;
      default: st_d = LIEH_IDLE;
    endcase
  end

  assign irq_d = |(full_evt & mask_q);

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      evt_q <= `LIEH_EVT_RESET;
      mask_q <= `LIEH_MASK_RESET;
      st_q <= LIEH_IDLE;
      rdata_q <= 32'h00000000;
      wr_hit_q <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      event_flags <= '0;
      irq <= 1'b0;
    end
    else
    begin
      evt_q <= evt_d;
      mask_q <= mask_d;
      st_q <= st_d;
      rdata_q <= rdata_d;
      wr_hit_q <= wr_hit_d;
      avs_waitrequest <= !(st_q == LIEH_IDLE && (avs_read || avs_write));
      avs_readdata <= rdata_d;
      event_flags <= view;
      irq <= irq_d;
    end
  end

  a_reinit_clears_ident: assert property (@(posedge clk) disable iff (!resetn)
    phy_bus_reset && !evt_q[17] |=> evt_q[17] && !evt_q[16]) // see RL3
    else $error("bus reinit did not clear ident done");
  a_reinit_sets: assert property (@(posedge clk) disable iff (!resetn)
    phy_bus_reset |=> evt_q[17]) // see RL1
    else $error("bus reinit not latched");
  a_ident_sets: assert property (@(posedge clk) disable iff (!resetn)
    ident_stream_done && !phy_bus_reset |=> evt_q[16]) // see RL2
    else $error("ident done not latched");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
    evt_q[15:10] == 6'h00 && event_flags[15:10] == 6'h00) // see RL4
    else $error("reserved bits nonzero");
  a_hw_set_wins: assert property (@(posedge clk) disable iff (!resetn)
    (hw_set[9:8] != 2'h0) |=> ((evt_q[9:8] & $past(hw_set[9:8])) == $past(hw_set[9:8]))) // see RL5, RL6, RL16
    else $error("hardware set lost");
  a_dma_qualified: assert property (@(posedge clk) disable iff (!resetn)
    request_send_done && !dma_irq_req[0] && !evt_q[0] && wr_set[0] == 1'b0
    |=> !evt_q[0]) // see RL14
    else $error("dma done set without request");
  a_dma_sets: assert property (@(posedge clk) disable iff (!resetn)
    resp_rx_dma_done && dma_irq_req[3] |=> evt_q[3]) // see RL11
    else $error("rx dma done not latched");
  a_tx_sets: assert property (@(posedge clk) disable iff (!resetn)
    response_send_done && dma_irq_req[1] |=> evt_q[1]) // see RL13
    else $error("tx response done not latched");
  a_pkt_sets: assert property (@(posedge clk) disable iff (!resetn)
    response_packet_stored |=> evt_q[5]) // see RL9
    else $error("packet stored not latched");
  a_summary_follow: assert property (@(posedge clk) disable iff (!resetn)
    1'b1 |=> event_flags[7] == $past(rx_sum) && event_flags[6] == $past(tx_sum)) // see RL7, RL8, RL17
    else $error("summary bits wrong");
  a_clear_view: assert property (@(posedge clk) disable iff (!resetn)
    st_q == LIEH_IDLE && avs_read && avs_address == `LIEH_OFS_CLR
    |=> avs_readdata == {14'h0000, $past(view) & $past(mask_q)}) // see RL15
    else $error("clear view read wrong");

  // handshake steps: accept while idle, then one low cycle of waitrequest
  sequence s_bus_accept;
    st_q == LIEH_IDLE && (avs_read || avs_write);
  endsequence

  sequence s_bus_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_bus_answer: assert property (@(posedge clk) disable iff (!resetn) // see RL15
    s_bus_accept |=> s_bus_answer)
    else $error("accepted request not answered once");

  a_bus_refuse: assert property (@(posedge clk) disable iff (!resetn) // see RL15
    s_bus_accept |=> ##1 avs_waitrequest [*2])
    else $error("request accepted inside refusal time");

  a_wait_idle: assert property (@(posedge clk) disable iff (!resetn) // see RL15
    !(st_q == LIEH_IDLE && (avs_read || avs_write)) |=> avs_waitrequest)
    else $error("waitrequest low without accept");

  a_readdata_hold: assert property (@(posedge clk) disable iff (!resetn) // see RL15
    !(st_q == LIEH_IDLE && (avs_read || avs_write)) |=> $stable(avs_readdata))
    else $error("read data changed without request");

  a_set_read: assert property (@(posedge clk) disable iff (!resetn) // see RL15
    s_bus_accept ##0 avs_read && avs_address == `LIEH_OFS_SET
    |=> avs_readdata == {14'h0000, $past(view)})
    else $error("set view read wrong");

  a_mask_read: assert property (@(posedge clk) disable iff (!resetn) // see RL15
    s_bus_accept ##0 avs_read && avs_address == `LIEH_OFS_MASK
    |=> avs_readdata == {14'h0000, $past(mask_q)})
    else $error("mask read wrong");

  a_unmapped_read: assert property (@(posedge clk) disable iff (!resetn) // see RL15
    s_bus_accept ##0 avs_read && avs_address != `LIEH_OFS_SET
      && avs_address != `LIEH_OFS_CLR && avs_address != `LIEH_OFS_MASK
    |=> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");

  a_reserved_read: assert property (@(posedge clk) disable iff (!resetn) // see RL4
    s_bus_accept ##0 avs_read
    |=> avs_readdata[31:18] == 14'h0000 && avs_readdata[15:10] == 6'h00)
    else $error("reserved read bits nonzero");

  a_set_write: assert property (@(posedge clk) disable iff (!resetn) // see RL16
    wr_hit_q && avs_address == `LIEH_OFS_SET && !hw_set[`LIEH_BIT_BUS_REINIT]
    |=> (evt_q & $past(wval)) == $past(wval))
    else $error("set write lost");

  a_clr_write: assert property (@(posedge clk) disable iff (!resetn) // see RL16
    wr_hit_q && avs_address == `LIEH_OFS_CLR
    |=> (evt_q & $past(wval) & ~$past(hw_set)) == 18'h00000)
    else $error("clear write lost");

  a_zero_write: assert property (@(posedge clk) disable iff (!resetn) // see RL16
    wr_hit_q && wval == 18'h00000 && hw_set == 18'h00000 |=> evt_q == $past(evt_q))
    else $error("zero write changed events");

  a_idle_hold: assert property (@(posedge clk) disable iff (!resetn) // see RL16
    hw_set == 18'h00000 && !wr_hit_q |=> evt_q == $past(evt_q))
    else $error("events changed with no cause");

  // ident done is the only bit a simultaneous bus reinit may take away
  a_hw_set_all: assert property (@(posedge clk) disable iff (!resetn) // see RL16
    hw_set != 18'h00000
    |=> (evt_q & $past(hw_set) & 18'h2FFFF) == ($past(hw_set) & 18'h2FFFF))
    else $error("hardware event lost");

  a_ident_rise_only: assert property (@(posedge clk) disable iff (!resetn) // see RL3
    ident_stream_done && evt_q[`LIEH_BIT_BUS_REINIT] |=> evt_q[`LIEH_BIT_NODE_IDENT])
    else $error("ident done cleared without new reinit");

  a_lock_err: assert property (@(posedge clk) disable iff (!resetn) // see RL5
    lock_resp_no_ack |=> evt_q[9])
    else $error("lock response error not latched");

  a_write_fault: assert property (@(posedge clk) disable iff (!resetn) // see RL6
    posted_write_fault |=> evt_q[8])
    else $error("buffered write fault not latched");

  a_pkt_req: assert property (@(posedge clk) disable iff (!resetn) // see RL10
    request_packet_stored |=> evt_q[4])
    else $error("request packet stored not latched");

  a_req_rx_dma: assert property (@(posedge clk) disable iff (!resetn) // see RL12
    req_rx_dma_done && dma_irq_req[2] |=> evt_q[2])
    else $error("request rx dma done not latched");

  a_req_tx_sets: assert property (@(posedge clk) disable iff (!resetn) // see RL14
    request_send_done && dma_irq_req[0] |=> evt_q[0])
    else $error("tx request done not latched");

  a_resp_rx_gated: assert property (@(posedge clk) disable iff (!resetn) // see RL11
    resp_rx_dma_done && !dma_irq_req[3] && !evt_q[3] && !wr_set[3] |=> !evt_q[3])
    else $error("response rx dma set without request");

  a_req_rx_gated: assert property (@(posedge clk) disable iff (!resetn) // see RL12
    req_rx_dma_done && !dma_irq_req[2] && !evt_q[2] && !wr_set[2] |=> !evt_q[2])
    else $error("request rx dma set without request");

  a_resp_tx_gated: assert property (@(posedge clk) disable iff (!resetn) // see RL13
    response_send_done && !dma_irq_req[1] && !evt_q[1] && !wr_set[1] |=> !evt_q[1])
    else $error("response tx done set without request");

  a_flags_copy: assert property (@(posedge clk) disable iff (!resetn) // see RL16
    1'b1 |=> event_flags == $past(view))
    else $error("event flags output wrong");
endmodule

// [sim/lieh_event_low_tb.sv]
`timescale 1ns/100ps
`include "lieh_cfg.svh"
module lieh_event_low_tb;
  import lieh_pkg::*;
  logic clk, resetn, rd, wr, wait_req, irq;
  logic [7:0] adr, rxe, rxn, txe, txn;
  logic [31:0] wd, rdata, q;
  logic [9:0] hw;
  logic [3:0] dreq, be;
  lieh_evt_t flags;
  int err_total, n_checks, cyc;
  int pos [10] = '{17, 16, 9, 8, 5, 4, 3, 2, 1, 0};
  lieh_event_low #(.NCHAN(8)) i_lieh_event_low (.clk(clk), .resetn(resetn),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wait_req),
    .phy_bus_reset(hw[0]), .ident_stream_done(hw[1]), .lock_resp_no_ack(hw[2]),
    .posted_write_fault(hw[3]), .response_packet_stored(hw[4]),
    .request_packet_stored(hw[5]), .resp_rx_dma_done(hw[6]), .req_rx_dma_done(hw[7]),
    .response_send_done(hw[8]), .request_send_done(hw[9]), .dma_irq_req(dreq),
    .rx_chan_event(rxe), .rx_chan_enable(rxn), .tx_chan_event(txe),
    .tx_chan_enable(txn), .event_flags(flags), .irq(irq));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      report_and_stop;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is sampled low at a rising edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (wait_req !== 1'b0) @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task hit(input int i, input logic r);
    hw[i] <= 1'b1;
    dreq <= (i > 5 && r) ? (4'h1 << (9 - i)) : 4'h0;
    @(posedge clk);
    hw <= 10'h000;
    dreq <= 4'h0;
    @(posedge clk);
  endtask
  initial
  begin
    {resetn, rd, wr, adr, wd, hw, dreq, rxe, rxn, txe, txn} = '0;
    be = 4'hF;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    bus(0, `LIEH_OFS_SET, 0); chk(q, 32'h0);
    bus(0, 8'h40, 0); chk(q, 32'h0);
    bus(1, `LIEH_OFS_MASK, 32'hFFFFFFFF);
    for (int i = 0; i < 10; i++)
    begin
      if (i > 5)
      begin
        hit(i, 1'b0);
        bus(0, `LIEH_OFS_SET, 0); chk(q, 32'h0);
      end
      hit(i, 1'b1);
      bus(0, `LIEH_OFS_SET, 0); chk(q, 32'h1 << pos[i]);
      chk({31'h0, irq}, 32'h1);
      bus(1, `LIEH_OFS_CLR, 32'hFFFFFFFF);
      bus(0, `LIEH_OFS_SET, 0); chk(q, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    hit(1, 1'b1);
    hit(0, 1'b1);
    bus(0, `LIEH_OFS_SET, 0); chk(q, 32'h20000);
    bus(1, `LIEH_OFS_SET, 32'hFFFFFFFF);
    bus(0, `LIEH_OFS_SET, 0); chk(q, {14'h0, `LIEH_LATCH_MASK});
    chk({14'h0, flags}, {14'h0, `LIEH_LATCH_MASK});
    bus(1, `LIEH_OFS_MASK, 32'h30);
    bus(0, `LIEH_OFS_CLR, 0); chk(q, 32'h30);
    bus(1, `LIEH_OFS_CLR, 32'hFFFFFFFF);
    bus(0, `LIEH_OFS_CLR, 0); chk(q, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rxe <= 8'h08;
    rxn <= 8'h04;
    bus(0, `LIEH_OFS_SET, 0); chk(q, 32'h0);
    rxn <= 8'h0C;
    txe <= 8'h80;
    txn <= 8'h80;
    bus(1, `LIEH_OFS_CLR, 32'hC0);
    bus(0, `LIEH_OFS_SET, 0); chk(q, 32'hC0);
    {rxe, rxn, txe, txn} <= '0;
    // a level held over the accept edge must beat the clear
    hw[2] <= 1'b1;
    bus(1, `LIEH_OFS_CLR, 32'h200);
    hw[2] <= 1'b0;
    bus(0, `LIEH_OFS_SET, 0); chk(q, 32'h200);
    bus(1, `LIEH_OFS_CLR, 32'h0);
    bus(0, `LIEH_OFS_SET, 0); chk(q, 32'h200);
    // only the enabled byte lane may set events
    bus(1, `LIEH_OFS_CLR, 32'hFFFFFFFF);
    be <= 4'h1;
    bus(1, `LIEH_OFS_SET, 32'hFFFFFFFF);
    be <= 4'hF;
    bus(0, `LIEH_OFS_SET, 0); chk(q, 32'h3F);
    // a reset in mid-run must drop every latched event
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    bus(0, `LIEH_OFS_SET, 0); chk(q, 32'h0);
    report_and_stop;
  end
endmodule
